/* src/ssc_pkg.sv */
package ssc_pkg;

  localparam int unsigned SSC_CLK_HZ = 100_000_000;
  localparam int unsigned SSC_DOC_SYS_HZ = 40_000_000;
  localparam int unsigned SSC_DOC_MAX_BPS = 20_000_000;
  localparam int unsigned SSC_DOC_MIN_MBPS = 305_180;
  localparam int unsigned SSC_MIN_DIV = SSC_DOC_SYS_HZ / SSC_DOC_MAX_BPS;

  localparam logic [7:0] SSC_ADDR_CTRL = 8'h00;
  localparam logic [7:0] SSC_ADDR_BAUD = 8'h04;
  localparam logic [7:0] SSC_ADDR_TXD = 8'h08;
  localparam logic [7:0] SSC_ADDR_RXD = 8'h0C;
  localparam logic [7:0] SSC_ADDR_STAT = 8'h10;
  localparam logic [7:0] SSC_ADDR_MASK = 8'h14;

  localparam int SSC_C_EN = 0;
  localparam int SSC_C_MASTER = 1;
  localparam int SSC_C_LSB = 2;
  localparam int SSC_C_CPOL = 3;
  localparam int SSC_C_CPHA = 4;
  localparam int SSC_C_LOOP = 5;
  localparam int SSC_C_TEN = 6;
  localparam int SSC_C_REN = 7;
  localparam int SSC_C_PEN = 8;
  localparam int SSC_C_BEN = 9;
  localparam int SSC_C_HDX = 10;
  localparam int SSC_C_LEN_LO = 12;

  localparam int SSC_S_TX = 0;
  localparam int SSC_S_RX = 1;
  localparam int SSC_S_TERR = 2;
  localparam int SSC_S_RERR = 3;
  localparam int SSC_S_PERR = 4;
  localparam int SSC_S_BERR = 5;
  localparam int SSC_S_BUSY = 8;
  localparam int SSC_S_TXFULL = 9;
  localparam int SSC_S_RXFULL = 10;

  localparam logic [15:0] SSC_CTRL_RST = 16'h0000;
  localparam logic [15:0] SSC_BAUD_RST = 16'h0000;
  localparam logic [5:0] SSC_MASK_RST = 6'h00;
  localparam logic [3:0] SSC_MIN_LEN = 4'h1;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] baud;
    logic [5:0] mask;
    logic [5:0] stat;
    logic [15:0] txbuf;
    logic txfull;
    logic [15:0] rxbuf;
    logic rxfull;
    logic [15:0] tsr;
    logic [15:0] rsr;
    logic loaded;
    logic busy;
    logic [4:0] edge_cnt;
    logic [15:0] bcnt;
    logic [15:0] gap;
    logic lvl;
    logic [2:0] sck_s;
    logic [2:0] mtsr_s;
    logic [2:0] mrst_s;
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [3:0] irq;
    logic [5:0] pins;
  } ssc_state_t;

  typedef struct packed {
    logic sclk_o;
    logic sclk_oe;
    logic mtsr_o;
    logic mtsr_oe;
    logic mrst_o;
    logic mrst_oe;
  } ssc_pins_t;

endpackage

/* src/ssc_top.sv */
// The AHB-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
// Functional notes
// RQ1 - Master drives the shift clock; slave shifts on an external master's clock.
// RQ2 - Full-duplex exchange, or half-duplex over one shared data line.
// RQ3 - Character length programmable from two through sixteen bits.
// RQ4 - Shift direction selectable, least or most significant bit first.
// RQ5 - Shift clock idle level programmable low or high, same at both ends.
// RQ6 - Phase selects shifting on leading or trailing edge, latching on the other.
// RQ7 - Baud generator covers half system clock down to the slowest rate.
// RQ8 - Shift clock period is two times reload plus one system clocks.
// RQ9 - Separate transmit, receive and error interrupt outputs.
// RQ10 - Transmit interrupt on buffer empty, receive interrupt on buffer full.
// RQ11 - Transmit and receive errors report buffer misuse through the error interrupt.
// RQ12 - Receive error on unread overwrite; transmit error on stale slave data.
// RQ13 - Phase and baud-rate errors flag bad serial data on the link.
// RQ14 - Each error check has its own enable bit.
// RQ15 - Loop-back routes transmitted data internally to the receiver.
// RQ16 - Three pins whose directions follow the master or slave role.
// RQ17 - Framing and clocking compatible with standard SPI parts.
module ssc_top
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  output logic irq_tx,
  output logic irq_rx,
  output logic irq_err,
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe,
  input wire logic mtsr_i,
  output logic mtsr_o,
  output logic mtsr_oe,
  input wire logic mrst_i,
  output logic mrst_o,
  output logic mrst_oe
);
  import ssc_pkg::*;

  ssc_state_t st_r;
  ssc_state_t st_nxt;

  logic en;
  logic master;
  logic lsb;
  logic cpha;
  logic hdx;
  logic [3:0] nb;
  logic [4:0] last_edge;
  logic tick;
  logic sedge;
  logic ev;
  logic go;
  logic is_shift;
  logic txbit;
  logic rxbit;
  logic rx_changed;
  logic txn;
  logic [15:0] lenmask;
  logic [5:0] set;
  logic [5:0] w1c;
  logic [31:0] rd;
  ssc_pins_t p;

  always_comb
  begin
    en = st_r.ctrl[SSC_C_EN];
    master = st_r.ctrl[SSC_C_MASTER];
    lsb = st_r.ctrl[SSC_C_LSB];
    cpha = st_r.ctrl[SSC_C_CPHA];
    hdx = st_r.ctrl[SSC_C_HDX];
    // Field holds length minus one; values below one act as two bits.
    nb = (st_r.ctrl[15:12] < SSC_MIN_LEN) ? SSC_MIN_LEN : st_r.ctrl[15:12]; // RQ3
    last_edge = {nb, 1'b1};
    lenmask = 16'hFFFF >> (4'hF - nb);
    txbit = lsb ? st_r.tsr[0] : st_r.tsr[nb]; // RQ4
    tick = st_r.busy && master && (st_r.bcnt == 16'h0000); // RQ8
    sedge = en && !master && (st_r.sck_s[1] != st_r.sck_s[2]); // RQ1
    // The receive line is the shared data line in half-duplex mode.
    if (st_r.ctrl[SSC_C_LOOP])
    begin
      rxbit = txbit; // RQ15
      rx_changed = 1'b0;
    end
    else if (master != hdx)
    begin
      rxbit = st_r.mrst_s[1]; // RQ2
      rx_changed = st_r.mrst_s[1] != st_r.mrst_s[2];
    end
    else
    begin
      rxbit = st_r.mtsr_s[1]; // RQ2
      rx_changed = st_r.mtsr_s[1] != st_r.mtsr_s[2];
    end
    go = st_r.busy || (sedge && st_r.loaded) || sedge;
    ev = master ? tick : sedge;
    is_shift = cpha ? !st_r.edge_cnt[0] : st_r.edge_cnt[0]; // RQ6
  end

  always_comb
  begin
    st_nxt = st_r;
    set = 6'h00;
    w1c = 6'h00;
    rd = 32'h0000_0000;
    st_nxt.sck_s = {st_r.sck_s[1:0], sclk_i};
    st_nxt.mtsr_s = {st_r.mtsr_s[1:0], mtsr_i};
    st_nxt.mrst_s = {st_r.mrst_s[1:0], mrst_i};
    st_nxt.hreadyout = 1'b1;
    st_nxt.hresp = 1'b0;

    // Data phase: writes take hwdata here.
    if (st_r.ap_valid && st_r.ap_write)
    begin
      unique case (st_r.ap_addr)
        SSC_ADDR_CTRL: st_nxt.ctrl = hwdata[15:0];
        SSC_ADDR_BAUD: st_nxt.baud = hwdata[15:0];
        SSC_ADDR_TXD:
        begin
          st_nxt.txbuf = hwdata[15:0];
          st_nxt.txfull = 1'b1;
        end
        SSC_ADDR_STAT: w1c = hwdata[5:0];
        SSC_ADDR_MASK: st_nxt.mask = hwdata[5:0];
        default: ;
      endcase
    end

    // Address phase: reads are decoded and registered for the data phase.
    st_nxt.ap_valid = hsel && hready && htrans[1];
    st_nxt.ap_write = hwrite;
    st_nxt.ap_addr = haddr[7:0];
    if (hsel && hready && htrans[1] && !hwrite)
    begin
      unique case (haddr[7:0])
        SSC_ADDR_CTRL: rd = {16'h0000, st_r.ctrl};
        SSC_ADDR_BAUD: rd = {16'h0000, st_r.baud};
        SSC_ADDR_RXD:
        begin
          rd = {16'h0000, st_r.rxbuf};
          st_nxt.rxfull = 1'b0;
        end
        SSC_ADDR_STAT:
          rd = {21'h000000, st_r.rxfull, st_r.txfull, st_r.busy, 2'b00, st_r.stat};
        SSC_ADDR_MASK: rd = {26'h0000000, st_r.mask};
        default: rd = 32'h0000_0000;
      endcase
      st_nxt.hrdata = rd;
    end

    // Preload the shifter from the buffer while idle.
    if (en && !st_r.busy && !st_r.loaded && st_nxt.txfull)
    begin
      st_nxt.tsr = st_nxt.txbuf;
      st_nxt.txfull = 1'b0;
      st_nxt.loaded = 1'b1;
      set[SSC_S_TX] = 1'b1; // RQ10
    end

    // Master starts a frame once data sits in the shifter.
    if (en && master && !st_r.busy && st_r.loaded)
    begin
      st_nxt.busy = 1'b1; // RQ1
      st_nxt.edge_cnt = 5'h00;
      st_nxt.bcnt = st_r.baud; // RQ7
      st_nxt.lvl = 1'b0;
    end

    if (st_r.busy && master)
    begin
      st_nxt.bcnt = tick ? st_r.baud : st_r.bcnt - 16'h0001; // RQ8
    end

    if (st_r.busy && !master)
    begin
      st_nxt.gap = (st_r.gap == 16'hFFFF) ? st_r.gap : st_r.gap + 16'h0001;
    end

    // Slave frame opens on its first clock edge.
    if (sedge && !st_r.busy)
    begin
      st_nxt.busy = 1'b1;
      st_nxt.edge_cnt = 5'h00;
      if (!st_r.loaded && st_r.ctrl[SSC_C_TEN]) // RQ14
      begin
        set[SSC_S_TERR] = 1'b1; // RQ12
      end
    end

    if (go && ev)
    begin
      st_nxt.lvl = !st_r.lvl;
      st_nxt.edge_cnt = st_r.edge_cnt + 5'h01;
      if (sedge && st_r.busy && st_r.ctrl[SSC_C_BEN] && (st_r.gap < st_r.baud))
      begin
        set[SSC_S_BERR] = 1'b1; // RQ13
      end
      st_nxt.gap = 16'h0000;
      if (is_shift)
      begin
        if (!(cpha && st_r.edge_cnt == 5'h00))
        begin
          st_nxt.tsr = lsb ? {1'b0, st_r.tsr[15:1]} : {st_r.tsr[14:0], 1'b0}; // RQ4
        end
      end
      else
      begin
        if (lsb)
        begin
          st_nxt.rsr = (st_r.rsr >> 1) | ({15'h0000, rxbit} << nb); // RQ4
        end
        else
        begin
          st_nxt.rsr = {st_r.rsr[14:0], rxbit};
        end
        if (!master && st_r.ctrl[SSC_C_PEN] && rx_changed)
        begin
          set[SSC_S_PERR] = 1'b1; // RQ13
        end
      end
      if (st_r.edge_cnt == last_edge)
      begin
        st_nxt.busy = 1'b0;
        st_nxt.edge_cnt = 5'h00;
        st_nxt.loaded = 1'b0;
        st_nxt.lvl = 1'b0;
        st_nxt.rxbuf = st_nxt.rsr & lenmask; // RQ3
        st_nxt.rxfull = 1'b1;
        set[SSC_S_RX] = 1'b1; // RQ10
        if (st_r.rxfull && st_r.ctrl[SSC_C_REN])
        begin
          set[SSC_S_RERR] = 1'b1; // RQ12
        end
      end
    end

    // Leaving enable aborts any frame.
    if (!en)
    begin
      st_nxt.busy = 1'b0;
      st_nxt.edge_cnt = 5'h00;
      st_nxt.lvl = 1'b0;
      st_nxt.loaded = 1'b0;
    end

    // A hardware event in the clearing cycle wins over the clear.
    st_nxt.stat = (st_r.stat & ~w1c) | set; // RQ11

    st_nxt.irq[0] = |(st_nxt.stat[1:0] & st_nxt.mask[1:0] & 2'b01); // RQ9
    st_nxt.irq[1] = |(st_nxt.stat[1:0] & st_nxt.mask[1:0] & 2'b10); // RQ9
    st_nxt.irq[2] = |(st_nxt.stat[5:2] & st_nxt.mask[5:2]); // RQ11
    st_nxt.irq[3] = |(st_nxt.stat & st_nxt.mask);

    // Pin directions follow the role; half-duplex data lines act open-drain.
    txn = lsb ? st_nxt.tsr[0] : st_nxt.tsr[nb]; // RQ4
    p.sclk_o = st_nxt.ctrl[SSC_C_CPOL] ^ st_nxt.lvl; // RQ5 RQ17
    p.sclk_oe = st_nxt.ctrl[SSC_C_EN] && st_nxt.ctrl[SSC_C_MASTER]; // RQ16
    p.mtsr_o = st_nxt.ctrl[SSC_C_HDX] ? 1'b0 : txn; // RQ2
    p.mtsr_oe = st_nxt.ctrl[SSC_C_EN] && st_nxt.ctrl[SSC_C_MASTER]
      && (!st_nxt.ctrl[SSC_C_HDX] || !txn); // RQ16
    p.mrst_o = st_nxt.ctrl[SSC_C_HDX] ? 1'b0 : txn; // RQ2
    p.mrst_oe = st_nxt.ctrl[SSC_C_EN] && !st_nxt.ctrl[SSC_C_MASTER]
      && (!st_nxt.ctrl[SSC_C_HDX] || !txn); // RQ16
    st_nxt.pins = p;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      st_r <= '0;
      st_r.ctrl <= SSC_CTRL_RST;
      st_r.baud <= SSC_BAUD_RST;
      st_r.mask <= SSC_MASK_RST;
      st_r.hreadyout <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign hrdata = st_r.hrdata;
  assign hreadyout = st_r.hreadyout;
  assign hresp = st_r.hresp;
  assign irq_tx = st_r.irq[0];
  assign irq_rx = st_r.irq[1];
  assign irq_err = st_r.irq[2];
  assign irq = st_r.irq[3];
  assign sclk_o = st_r.pins[5];
  assign sclk_oe = st_r.pins[4];
  assign mtsr_o = st_r.pins[3];
  assign mtsr_oe = st_r.pins[2];
  assign mrst_o = st_r.pins[1];
  assign mrst_oe = st_r.pins[0];

endmodule

/* tb/ssc_chk.sv */
`timescale 1ns/1ps
module ssc_chk
  import ssc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic irq_err,
  input wire logic sclk_o,
  input wire logic sclk_oe,
  input wire logic mtsr_oe,
  input wire logic mrst_oe
);
  logic aw_r;
  logic [7:0] aa_r;
  logic [15:0] ctl_r;
  logic [15:0] bd_r;
  logic [7:0] hc_r;
  logic sp_r;
  logic ms;
  logic cw;
  assign ms = ctl_r[SSC_C_MASTER] & ctl_r[SSC_C_EN];
  assign cw = aw_r & hready & (aa_r == SSC_ADDR_CTRL);
  // Shadows the control and reload words and counts cycles since the clock last moved, restarting from 0x80 on a control write.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      aw_r <= 1'b0;
      ctl_r <= SSC_CTRL_RST;
      bd_r <= SSC_BAUD_RST;
      hc_r <= 8'h00;
    end
    else
    begin
      if (hready)
      begin
        aw_r <= hsel & htrans[1] & hwrite;
        aa_r <= haddr[7:0];
      end
      if (cw)
      begin
        ctl_r <= hwdata[15:0];
      end
      if (aw_r & hready & (aa_r == SSC_ADDR_BAUD))
      begin
        bd_r <= hwdata[15:0];
      end
      if (sclk_o != sp_r)
        hc_r <= 8'h01;
      else if (cw)
        hc_r <= 8'h80;
      else if (hc_r != 8'hFF)
        hc_r <= hc_r + 8'h01;
    end
    sp_r <= sclk_o;
  end
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  a_master_clk_drive: assert property (ms [*3] |-> sclk_oe)
    else $error("master leaves shift clock undriven");
  a_master_rx_input: assert property (ms [*3] |-> !mrst_oe)
    else $error("master drives its receive pin");
  a_slave_clk_input: assert property (!ctl_r[SSC_C_MASTER] [*3] |-> !sclk_oe)
    else $error("slave drives the shift clock");
  a_slave_tx_input: assert property (!ctl_r[SSC_C_MASTER] [*3] |-> !mtsr_oe)
    else $error("slave drives the master data pin");
  a_half_period: assert property (ms && (sclk_o != sp_r) |-> hc_r > bd_r)
    else $error("shift clock half period too short");
  a_idle_level: assert property (ms && hc_r > 8'h28 && hc_r < 8'h80
    |-> sclk_o == ctl_r[SSC_C_CPOL])
    else $error("shift clock idles at wrong level");
  a_err_enabled: assert property ($rose(irq_err) |-> |ctl_r[SSC_C_BEN:SSC_C_TEN])
    else $error("error interrupt with all checks off");
  a_bus_wait: assert property (!hreadyout |-> ##[1:16] hreadyout)
    else $error("bus stalled too long");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
endmodule

bind ssc_top ssc_chk u_chk (.clk_sys, .srst, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hreadyout, .hresp, .irq_err, .sclk_o, .sclk_oe, .mtsr_oe, .mrst_oe);

/* tb/ssc_peer.sv */
`timescale 1ns/1ps
module ssc_peer
(
  input wire logic sclk,
  input wire logic mtsr,
  output logic mrst,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic lsb,
  input wire logic [4:0] len,
  input wire logic [15:0] tx_word,
  output logic [15:0] rx_word
);
  int k = 0;
  logic [15:0] acc = 16'h0;
  initial rx_word = 16'h0;
  // A fresh word restarts the frame and presents its first bit.
  always @(tx_word)
  begin
    k = 0;
    mrst <= lsb ? tx_word[0] : tx_word[len - 1];
  end
  always @(sclk)
  begin
    if ((sclk != cpol) ^ cpha)
    begin
      acc[lsb ? k : len - 1 - k] = mtsr;
      k++;
      if (k == len)
      begin
        rx_word = acc;
        k = 0;
      end
    end
    else
    begin
      mrst <= lsb ? tx_word[k] : tx_word[len - 1 - k];
    end
  end
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin miscompares++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module testbench;
  import ssc_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, q, ev, mv;
  logic hready, hresp, irq, irq_tx, irq_rx, irq_err, pm;
  logic sclk_o, sclk_oe, mtsr_o, mtsr_oe, mrst_o, mrst_oe, sclk_w, mtsr_w, mrst_w;
  logic cv = 1'b0;
  logic bs = 1'b0;
  logic bo = 1'b0;
  logic [15:0] c = 16'h0;
  logic [15:0] r = 16'h0059;
  logic [15:0] pt = 16'h0;
  logic [15:0] pr, lm;
  logic [31:0] eq[$];
  logic [31:0] mq[$];
  logic [15:0] md[4] = '{16'h1083, 16'hF08F, 16'h6093, 16'hF09F};
  int miscompares = 0;
  int comparisons = 0;
  assign sclk_w = sclk_oe ? sclk_o : (c[SSC_C_CPOL] ^ bs);
  assign mtsr_w = mtsr_oe ? mtsr_o : (c[SSC_C_MASTER] ? ~mtsr_o : bo);
  assign mrst_w = mrst_oe ? mrst_o : pm;
  ssc_top uut (.clk_sys, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready, .hrdata, .hreadyout(hready), .hresp, .irq, .irq_tx, .irq_rx, .irq_err,
    .sclk_i(sclk_w), .sclk_o, .sclk_oe, .mtsr_i(mtsr_w), .mtsr_o, .mtsr_oe,
    .mrst_i(mrst_w), .mrst_o, .mrst_oe);
  ssc_peer peer (.sclk(sclk_w), .mtsr(mtsr_w), .mrst(pm), .cpol(c[SSC_C_CPOL]),
    .cpha(c[SSC_C_CPHA]), .lsb(c[SSC_C_LSB]), .len({1'b0, c[15:12]} + 5'h01),
    .tx_word(pt), .rx_word(pr));
  initial forever #5 clk_sys = ~clk_sys;
  function automatic logic [15:0] nx(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d, input logic k);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk_sys); while (!hready);
    htrans <= 2'h0;
    hwdata <= d;
    cv <= k;
    do @(posedge clk_sys); while (!hready);
    q = hrdata;
    cv <= 1'b0;
  endtask
  task automatic ck(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    eq.push_back(e & m);
    mq.push_back(m);
    xf(1'b0, a, 32'h0, 1'b1);
  endtask
  task automatic run(input logic [15:0] cc);
    c <= cc;
    xf(1'b1, SSC_ADDR_BAUD, 32'h2, 1'b0);
    xf(1'b1, SSC_ADDR_CTRL, {16'h0, cc}, 1'b0);
    xf(1'b1, SSC_ADDR_STAT, 32'h3F, 1'b0);
    r = nx(r);
    pt <= r;
    r = nx(r);
    xf(1'b1, SSC_ADDR_TXD, {16'h0, r}, 1'b0);
    q = 32'h0;
    for (int i = 0; i < 300 && !q[SSC_S_RX]; i++)
      xf(1'b0, SSC_ADDR_STAT, 32'h0, 1'b0);
    `CHK("frame done", 1'b1, q[SSC_S_RX])
  endtask
  task automatic end_sim();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Checks each read made through ck against the oldest noted expectation.
  always @(posedge clk_sys)
  begin
    if (cv && hready)
    begin
      ev = eq.pop_front();
      mv = mq.pop_front();
      `CHK("register read", ev, hrdata & mv)
    end
  end
  initial
  begin
    #300000;
    miscompares++;
    end_sim();
  end
  initial
  begin
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    ck(SSC_ADDR_CTRL, 32'h0, 32'hFFFF);
    ck(SSC_ADDR_BAUD, 32'h0, 32'hFFFF);
    xf(1'b1, 8'h18, 32'hFFFF, 1'b0);
    ck(SSC_ADDR_MASK, 32'h0, 32'h3F);
    $display("reset and map test done");
    foreach (md[i])
    begin
      run(md[i]);
      lm = 16'hFFFF >> (4'hF - md[i][15:12]);
      ck(SSC_ADDR_STAT, 32'h3, 32'h3F);
      ck(SSC_ADDR_RXD, {16'h0, pt & lm}, {16'h0, lm});
      `CHK("peer word", r & lm, pr & lm)
    end
    $display("mode test done");
    xf(1'b1, SSC_ADDR_MASK, 32'h3F, 1'b0);
    run(16'h7083);
    run(16'h7083);
    ck(SSC_ADDR_STAT, 32'h8, 32'h8);
    `CHK("error irq", 1'b1, irq_err)
    `CHK("irq", 1'b1, irq)
    xf(1'b1, SSC_ADDR_STAT, 32'h3F, 1'b0);
    xf(1'b0, SSC_ADDR_RXD, 32'h0, 1'b0);
    `CHK("irq cleared", 1'b0, irq)
    $display("overrun test done");
    xf(1'b1, SSC_ADDR_MASK, 32'h0, 1'b0);
    run(16'h7003);
    run(16'h7003);
    ck(SSC_ADDR_STAT, 32'h2, 32'h3E);
    `CHK("masked irq", 1'b0, irq)
    xf(1'b0, SSC_ADDR_RXD, 32'h0, 1'b0);
    $display("mask test done");
    run(16'hF023);
    ck(SSC_ADDR_RXD, {16'h0, r}, 32'hFFFF);
    $display("loop test done");
    c <= 16'h7041;
    xf(1'b1, SSC_ADDR_CTRL, 32'h7041, 1'b0);
    xf(1'b1, SSC_ADDR_STAT, 32'h3F, 1'b0);
    r = nx(r);
    for (int i = 7; i >= 0; i--)
    begin
      bo <= r[i];
      repeat (4) @(posedge clk_sys);
      bs <= 1'b1;
      repeat (4) @(posedge clk_sys);
      bs <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
    repeat (4) @(posedge clk_sys);
    `CHK("slave mrst drive", 1'b1, mrst_oe)
    ck(SSC_ADDR_STAT, 32'h6, 32'h3E);
    ck(SSC_ADDR_RXD, {24'h0, r[7:0]}, 32'hFF);
    $display("slave test done");
    end_sim();
  end
endmodule
